// ### hw/status_pkg.sv
// Purpose: Shared constants for the wind sensor status and error logic
// Assumes: MCLK at 10 MHz
// Notes: Times are kept in their own unit, cycle counts derive from them
`default_nettype none
package status_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_HZ = 1000;                       // Millisecond tick rate
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int ERR_TIMEOUT_S = 30;                   // Stale measurement time
    localparam int STATIC_FAULT_S = 60;                  // Persistent fault time
    localparam int ERR_TIMEOUT_MS = ERR_TIMEOUT_S * 1000;
    localparam int STATIC_FAULT_MS = STATIC_FAULT_S * 1000;
    localparam logic [15:0] AVG_LONG_S = 16'h001e;       // 30 s averaging threshold
    // General status byte fields
    localparam int GS_FAULT = 0;
    localparam int GS_FILL_LO = 1;
    localparam int GS_PLAUS = 4;
    localparam int GS_STATIC = 5;
    localparam int GS_HEAT_EN = 6;
    localparam int GS_HEAT_PWR = 7;
    // Monitoring status byte fields
    localparam int MS_FAULT = 0;
    localparam int MS_PLAUS = 1;
    localparam int MS_HEAT_EN = 2;
    localparam int MS_HEAT_PWR = 3;
    localparam int MS_OVERCUR = 4;
    localparam int MS_THERM_OPEN = 5;
    localparam int MS_TEMP_HIGH = 6;
    localparam int MS_RSVD = 7;
    // Temperatures in signed whole degrees
    localparam logic signed [11:0] THERM_MIN_C = -12'sd50;
    localparam logic signed [11:0] THERM_MAX_C = 12'sd80;
    localparam logic signed [11:0] UNIT_HOT_C = 12'sd60;
    localparam logic [7:0] ANA_MIN = 8'h00;
    localparam logic [7:0] ANA_MAX = 8'hff;
    localparam logic [7:0] ZERO8 = 8'h00;
endpackage : status_pkg
`default_nettype wire

// ### hw/ms_timer.sv
// Purpose: Millisecond counter that flags when a condition has held past a limit
// Assumes: tick is a one-cycle enable at the millisecond rate
// Notes: Restart clears the count; saturates at the limit
`default_nettype none
module ms_timer #(
    parameter int LIMIT_MS = 30000
) (
    input wire logic clk,        // System clock
    input wire logic rst,        // Async reset, active high
    input wire logic tick,       // Millisecond enable
    input wire logic restart,    // Clears the count
    output logic expired         // Limit reached
);
    logic [31:0] cnt_r, cnt_nxt;
    logic exp_r, exp_nxt;

    // Count ticks until the limit, then hold
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = exp_r;
        if (restart) begin
            cnt_nxt = '0;
            exp_nxt = 1'b0;
        end else if (tick && !exp_r) begin
            cnt_nxt = cnt_r + 32'd1;
            exp_nxt = (cnt_r + 32'd1) >= 32'(LIMIT_MS);
        end
    end

    // Register count and flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;
endmodule // ms_timer
`default_nettype wire

// ### hw/wind_status.sv
// Purpose: Builds status bytes, voltage byte and error reactions for telegrams
// Assumes: All inputs synchronous to MCLK; one clock domain
// Notes: Status, supply and telegram flag outputs are snapshots taken on each telegram assembly request; analogue and fault outputs update every cycle
`default_nettype none
module wind_status
    import status_pkg::*;
#(
    parameter int FILL_W = 8,                  // Width of buffer fill counts
    parameter int ERR_MS = ERR_TIMEOUT_MS,     // Stale measurement time in ms
    parameter int STATIC_MS = STATIC_FAULT_MS, // Persistent fault time in ms
    parameter int TICK_DIV = TICK_CYCLES       // Cycles per millisecond tick
) (
    input wire logic MCLK,                             // System clock, 10 MHz
    input wire logic SYS_RST,                          // Async reset, active high
    input wire logic [15:0] ERROR_TIMEOUT_SETTING,     // Averaging time in seconds
    input wire logic NEW_MEAS,                         // Pulse: new measurement obtained
    input wire logic [FILL_W-1:0] BUF_VALID,           // Valid entries in averaging buffer
    input wire logic [FILL_W-1:0] BUF_SIZE,            // Averaging buffer capacity
    input wire logic PLAUS_ON,                         // Plausibility check enabled
    input wire logic VT_VIOLATION,                     // Virtual temperature out of range
    input wire logic HEAT_CTRL_EN,                     // Heater control activated
    input wire logic HEAT_PWR,                         // Bottom heater drawing power
    input wire logic HEAT_OVERCUR,                     // Heater current above range
    input wire logic signed [11:0] THERM_C,            // Heater thermistor, degrees
    input wire logic signed [11:0] UNIT_TEMP_C,        // Internal temperature, degrees
    input wire logic [9:0] SUPPLY_PEAK_QV,             // Peak supply, quarter volts
    input wire logic ERR_TLG_CFG,                      // Error telegram configured
    input wire logic ANALOG_ACTIVE,                    // Analogue outputs enabled
    input wire logic FAULT_OUTPUT_LEVEL_SELECT,        // 1: max on fault, 0: min
    input wire logic [7:0] ANALOG_MEAS,                // Normal analogue value
    input wire logic SNAP_REQ,                         // Pulse: assemble telegram
    output logic [7:0] GEN_STATUS,                     // General status byte
    output logic [7:0] MON_STATUS,                     // Monitoring status byte
    output logic [7:0] SUPPLY_BYTE,                    // Supply voltage byte
    output logic SEND_ERR_TLG,                         // Send error telegram
    output logic MEAS_VALID,                           // Values may be sent
    output logic SNAP_DONE,                            // Pulse: snapshot ready
    output logic [7:0] ANALOG_OUT,                     // Analogue output value
    output logic FAULT                                 // Live fault level
);

    logic [31:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic stale, persist, fault_c, persist_cond;
    logic [2:0] fill_code;
    logic [7:0] gen_c, mon_c, volt_c, ana_c;
    logic [7:0] gen_r, gen_nxt, mon_r, mon_nxt, volt_r, volt_nxt, ana_r, ana_nxt;
    logic err_r, err_nxt, val_r, val_nxt, done_r, done_nxt, flt_r, flt_nxt;

    // Millisecond enable divider
    always_comb begin
        div_nxt = div_r + 32'd1;
        tick_nxt = 1'b0;
        if (div_r >= 32'(TICK_DIV - 1)) begin
            div_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Stale measurement watchdog, restarted by every new value
    ms_timer #(.LIMIT_MS(ERR_MS)) u_stale (
        .clk(MCLK),
        .rst(SYS_RST),
        .tick(tick_r),
        .restart(NEW_MEAS),
        .expired(stale)
    );

    // Persistent fault watchdog, restarted while no fault condition holds
    assign persist_cond = VT_VIOLATION || stale || (BUF_VALID == '0);
    ms_timer #(.LIMIT_MS(STATIC_MS)) u_persist (
        .clk(MCLK),
        .rst(SYS_RST),
        .tick(tick_r),
        .restart(!persist_cond),
        .expired(persist)
    );

    // Occupancy code: smallest n with valid*8 <= (n+1)*size
    always_comb begin
        logic [FILL_W+3:0] scaled;
        logic [FILL_W+3:0] bound;
        bound = '0;
        scaled = {3'b000, BUF_VALID, 1'b0} << 2;
        fill_code = 3'd7;
        for (int n = 6; n >= 0; n--) begin
            bound = (FILL_W + 4)'(n + 1) * {4'h0, BUF_SIZE};
            if (scaled <= bound) begin
                fill_code = 3'(n);
            end
        end
    end

    // Fault decision depends on the averaging time
    always_comb begin
        if (ERROR_TIMEOUT_SETTING < AVG_LONG_S) begin
            fault_c = stale;
        end else begin
            fault_c = (BUF_VALID == '0);
        end
    end

    // Status byte assembly
    always_comb begin
        gen_c = ZERO8;
        gen_c[GS_FAULT] = fault_c;
        gen_c[GS_FILL_LO +: 3] = fill_code;
        gen_c[GS_PLAUS] = PLAUS_ON;
        gen_c[GS_STATIC] = persist;
        gen_c[GS_HEAT_EN] = HEAT_CTRL_EN;
        gen_c[GS_HEAT_PWR] = HEAT_PWR;
        mon_c = ZERO8;
        mon_c[MS_FAULT] = fault_c;
        mon_c[MS_PLAUS] = PLAUS_ON;
        mon_c[MS_HEAT_EN] = HEAT_CTRL_EN;
        mon_c[MS_HEAT_PWR] = HEAT_PWR;
        mon_c[MS_OVERCUR] = HEAT_OVERCUR;
        mon_c[MS_THERM_OPEN] = (THERM_C < THERM_MIN_C) || (THERM_C > THERM_MAX_C);
        mon_c[MS_TEMP_HIGH] = (UNIT_TEMP_C > UNIT_HOT_C);
        mon_c[MS_RSVD] = 1'b0;
    end

    // Voltage byte saturates at the top code; input is already the peak
    assign volt_c = (SUPPLY_PEAK_QV > 10'(ANA_MAX)) ? ANA_MAX : SUPPLY_PEAK_QV[7:0];

    // Analogue output forced to a defined level on fault
    always_comb begin
        ana_c = ANALOG_MEAS;
        if (fault_c) begin
            ana_c = FAULT_OUTPUT_LEVEL_SELECT ? ANA_MAX : ANA_MIN;
        end
        if (!ANALOG_ACTIVE) begin
            ana_c = ANA_MIN;
        end
    end

    // Snapshot registers: status taken once per telegram request
    always_comb begin
        gen_nxt = gen_r;
        mon_nxt = mon_r;
        volt_nxt = volt_r;
        err_nxt = err_r;
        val_nxt = val_r;
        done_nxt = 1'b0;
        ana_nxt = ana_c;
        flt_nxt = fault_c;
        if (SNAP_REQ) begin
            gen_nxt = gen_c;
            mon_nxt = mon_c;
            volt_nxt = volt_c;
            err_nxt = fault_c && ERR_TLG_CFG;
            val_nxt = !fault_c || !ERR_TLG_CFG;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gen_r <= ZERO8;
            mon_r <= ZERO8;
            volt_r <= ZERO8;
            ana_r <= ANA_MIN;
            err_r <= 1'b0;
            val_r <= 1'b1;
            done_r <= 1'b0;
            flt_r <= 1'b0;
        end else begin
            gen_r <= gen_nxt;
            mon_r <= mon_nxt;
            volt_r <= volt_nxt;
            ana_r <= ana_nxt;
            err_r <= err_nxt;
            val_r <= val_nxt;
            done_r <= done_nxt;
            flt_r <= flt_nxt;
        end
    end

    assign GEN_STATUS = gen_r;
    assign MON_STATUS = mon_r;
    assign SUPPLY_BYTE = volt_r;
    assign ANALOG_OUT = ana_r;
    assign SEND_ERR_TLG = err_r;
    assign MEAS_VALID = val_r;
    assign SNAP_DONE = done_r;
    assign FAULT = flt_r;

    // Checker helpers: cycles since the last new value and since a fault began
    logic [31:0] quiet_r, quiet_nxt, held_r, held_nxt;
    always_comb begin
        quiet_nxt = quiet_r;
        held_nxt = held_r;
        if (NEW_MEAS) begin
            quiet_nxt = '0;
        end else if (quiet_r != '1) begin
            quiet_nxt = quiet_r + 32'd1;
        end
        if (!persist_cond) begin
            held_nxt = '0;
        end else if (held_r != '1) begin
            held_nxt = held_r + 32'd1;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            quiet_r <= '0;
            held_r <= '0;
        end else begin
            quiet_r <= quiet_nxt;
            held_r <= held_nxt;
        end
    end

    // Checks: snapshot contents
    a_snap_fault: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> GEN_STATUS[GS_FAULT] == $past(fault_c))
        else $error("fault bit not captured");
    a_long_avg: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && ERROR_TIMEOUT_SETTING >= AVG_LONG_S && BUF_VALID == '0
        |=> GEN_STATUS[GS_FAULT])
        else $error("empty buffer not flagged");
    a_fill_full: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && BUF_VALID == BUF_SIZE && BUF_SIZE != '0
        |=> GEN_STATUS[3:1] == 3'h7)
        else $error("full buffer code wrong");
    a_fill_low: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && BUF_VALID == '0 |=> GEN_STATUS[3:1] == 3'h0)
        else $error("empty buffer code wrong");
    a_fill_code: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && BUF_VALID != '0 && BUF_VALID <= BUF_SIZE
        |=> int'($past(BUF_VALID)) * 8 <= (int'(GEN_STATUS[3:1]) + 1) * int'($past(BUF_SIZE))
        && int'($past(BUF_VALID)) * 8 > int'(GEN_STATUS[3:1]) * int'($past(BUF_SIZE)))
        else $error("occupancy code outside its eighth");
    a_plaus_bits: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> GEN_STATUS[GS_PLAUS] == $past(PLAUS_ON)
        && MON_STATUS[MS_PLAUS] == $past(PLAUS_ON))
        else $error("plausibility bits wrong");
    a_heat_bits: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> GEN_STATUS[GS_HEAT_EN] == MON_STATUS[MS_HEAT_EN]
        && GEN_STATUS[GS_HEAT_PWR] == MON_STATUS[MS_HEAT_PWR])
        else $error("heater bits disagree");
    a_heat_pwr_gen: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> GEN_STATUS[GS_HEAT_PWR] == $past(HEAT_PWR))
        else $error("heater power bit wrong");
    a_mon_fault: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> MON_STATUS[MS_FAULT] == $past(fault_c))
        else $error("monitor fault bit wrong");
    a_heat_en_mon: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> MON_STATUS[MS_HEAT_EN] == $past(HEAT_CTRL_EN))
        else $error("monitor heater enable bit wrong");
    a_heat_pwr_mon: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> MON_STATUS[MS_HEAT_PWR] == $past(HEAT_PWR))
        else $error("monitor heater power bit wrong");
    a_overcur: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> MON_STATUS[MS_OVERCUR] == $past(HEAT_OVERCUR))
        else $error("overcurrent bit wrong");
    a_therm_open: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> MON_STATUS[MS_THERM_OPEN]
        == ($past(THERM_C) < THERM_MIN_C || $past(THERM_C) > THERM_MAX_C))
        else $error("thermistor open flag wrong");
    a_hot_warn: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && UNIT_TEMP_C > UNIT_HOT_C |=> MON_STATUS[MS_TEMP_HIGH])
        else $error("high temperature not warned");
    a_volt_sat: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && SUPPLY_PEAK_QV > 10'h0ff |=> SUPPLY_BYTE == 8'hff)
        else $error("supply byte not saturated");
    a_volt_pass: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ && SUPPLY_PEAK_QV <= 10'h0ff |=> {2'h0, SUPPLY_BYTE} == $past(SUPPLY_PEAK_QV))
        else $error("supply byte wrong");
    a_snap_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !SNAP_REQ |=> $stable(GEN_STATUS) && $stable(MON_STATUS))
        else $error("snapshot changed between requests");
    a_done_pulse: assert property (@(posedge MCLK) disable iff (SYS_RST)
        1'b1 |=> SNAP_DONE == $past(SNAP_REQ))
        else $error("snapshot ready pulse wrong");

    // Checks: watchdog timing against the helper counters
    a_stale_late: assert property (@(posedge MCLK) disable iff (SYS_RST)
        quiet_r >= 32'(ERR_MS * TICK_DIV) |-> stale)
        else $error("stale measurement not flagged in time");
    a_stale_early: assert property (@(posedge MCLK) disable iff (SYS_RST)
        quiet_r <= 32'((ERR_MS - 1) * TICK_DIV) |-> !stale)
        else $error("stale measurement flagged too early");
    a_persist_late: assert property (@(posedge MCLK) disable iff (SYS_RST)
        held_r >= 32'(STATIC_MS * TICK_DIV) |-> persist)
        else $error("persistent fault not flagged in time");
    a_persist_early: assert property (@(posedge MCLK) disable iff (SYS_RST)
        held_r <= 32'((STATIC_MS - 1) * TICK_DIV) |-> !persist)
        else $error("persistent fault flagged too early");

    // Checks: telegram and analogue reactions
    a_err_tlg: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SEND_ERR_TLG |-> !MEAS_VALID)
        else $error("error telegram with valid data");
    a_err_cond: assert property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_REQ |=> SEND_ERR_TLG == ($past(fault_c) && $past(ERR_TLG_CFG)))
        else $error("error telegram choice wrong");
    a_valid_flag: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !SEND_ERR_TLG |-> MEAS_VALID)
        else $error("normal telegram marked invalid");
    a_ana_fault: assert property (@(posedge MCLK) disable iff (SYS_RST)
        fault_c && ANALOG_ACTIVE && FAULT_OUTPUT_LEVEL_SELECT |=> ANALOG_OUT == ANA_MAX)
        else $error("analogue not forced high");
    a_ana_low: assert property (@(posedge MCLK) disable iff (SYS_RST)
        fault_c && ANALOG_ACTIVE && !FAULT_OUTPUT_LEVEL_SELECT |=> ANALOG_OUT == ANA_MIN)
        else $error("analogue not forced low");
    a_ana_normal: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !fault_c && ANALOG_ACTIVE |=> ANALOG_OUT == $past(ANALOG_MEAS))
        else $error("analogue value not passed");
    a_fault_live: assert property (@(posedge MCLK) disable iff (SYS_RST)
        1'b1 |=> FAULT == $past(fault_c))
        else $error("live fault level wrong");

    // Covers for the main scenarios
    c_fault_seen: cover property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_DONE && GEN_STATUS[GS_FAULT]);
    c_static: cover property (@(posedge MCLK) disable iff (SYS_RST) persist);
    c_err_tlg: cover property (@(posedge MCLK) disable iff (SYS_RST) SEND_ERR_TLG);
    c_ana_low: cover property (@(posedge MCLK) disable iff (SYS_RST)
        ANALOG_ACTIVE && FAULT && ANALOG_OUT == ANA_MIN);
    c_fill_full: cover property (@(posedge MCLK) disable iff (SYS_RST)
        SNAP_DONE && GEN_STATUS[3:1] == 3'h7);
endmodule // wind_status
`default_nettype wire

// ### dv/host_reader.sv
// Purpose: Host model that requests and reads telegram status snapshots
// Assumes: The answer comes on the cycle after the request edge
// Notes: Gives up after four cycles without an answer
`default_nettype none
module host_reader (
    input wire logic clk,          // System clock
    input wire logic done,         // Snapshot ready
    input wire logic [23:0] bytes, // General, monitor and supply bytes
    input wire logic [1:0] flags,  // Error telegram, values valid
    output logic req               // Snapshot request
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = 1'b0;
    // One read: request for one edge, then capture on the ready cycle
    task automatic read_tlg(output logic [25:0] cap, output bit ok);
        ok = 1'b0;
        cap = '0;
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            if (done === 1'b1) begin
                cap = {bytes, flags};
                ok = 1'b1;
            end
        end
    endtask
endmodule // host_reader
`default_nettype wire

// ### dv/wind_status_bench.sv
// Purpose: Self-checking bench for the wind sensor status logic
// Assumes: Short timer parameters, tick every four cycles
// Notes: Bytes are judged from host captures outside t_reset and t_hold, live outputs at falling edges
`default_nettype none
module wind_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, new_meas = 1'b0, plaus = 1'b0, vt = 1'b0, meas_run = 1'b1;
    logic hen = 1'b0, hpwr = 1'b0, ocur = 1'b0, err_cfg = 1'b0, ana_on = 1'b0, sel = 1'b0;
    logic [15:0] avg_s = 16'h001e;
    logic [7:0] valid = 8'h04, size = 8'h08, ana_in = 8'h5a, gen, mon, sup, ana_out;
    logic signed [11:0] therm = 12'sd20, unit = 12'sd20;
    logic [9:0] supply = 10'h060;
    logic [1:0] mcnt = 2'h0;
    logic [25:0] cap;
    logic req, done, send_err, meas_ok, fault;
    bit ok;
    int n_mismatch = 0, n_tests = 0;
    // Clock and background measurement pulses every fourth cycle
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        mcnt <= mcnt + 2'h1;
        new_meas <= meas_run && (mcnt == 2'h0);
    end
    wind_status #(.FILL_W(8), .ERR_MS(3), .STATIC_MS(6), .TICK_DIV(4)) u_dut (
        .MCLK(mclk), .SYS_RST(rst), .ERROR_TIMEOUT_SETTING(avg_s), .NEW_MEAS(new_meas),
        .BUF_VALID(valid), .BUF_SIZE(size), .PLAUS_ON(plaus), .VT_VIOLATION(vt),
        .HEAT_CTRL_EN(hen), .HEAT_PWR(hpwr), .HEAT_OVERCUR(ocur), .THERM_C(therm),
        .UNIT_TEMP_C(unit), .SUPPLY_PEAK_QV(supply), .ERR_TLG_CFG(err_cfg),
        .ANALOG_ACTIVE(ana_on), .FAULT_OUTPUT_LEVEL_SELECT(sel), .ANALOG_MEAS(ana_in),
        .SNAP_REQ(req), .GEN_STATUS(gen), .MON_STATUS(mon), .SUPPLY_BYTE(sup),
        .SEND_ERR_TLG(send_err), .MEAS_VALID(meas_ok), .SNAP_DONE(done),
        .ANALOG_OUT(ana_out), .FAULT(fault));
    host_reader u_host (.clk(mclk), .done(done), .bytes({gen, mon, sup}),
        .flags({send_err, meas_ok}), .req(req));
    // Verdict and end of run
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Host read with a missing answer treated as fatal to the run
    task automatic snap;
        u_host.read_tlg(cap, ok);
        if (!ok) begin
            chk({7'h00, done}, 8'h01);
            end_sim;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Reset state of the status, supply, telegram flag and analogue outputs
    task automatic t_reset;
        @(negedge mclk);
        chk(gen, 8'h00);
        chk(mon, 8'h00);
        chk(sup, 8'h00);
        chk({6'h00, send_err, meas_ok}, 8'h01);
        chk(ana_out, 8'h00);
    endtask
    // Status bits in both bytes and fill code in the general byte
    task automatic t_bits(input logic p, he, hp, oc, input logic [7:0] v, s, input logic [2:0] c);
        logic f;
        f = (v == 8'h00);
        @(posedge mclk);
        {plaus, hen, hpwr, ocur, valid, size} <= {p, he, hp, oc, v, s};
        snap;
        chk(cap[25:18], {hp, he, 1'b0, p, c, f});
        chk(cap[17:10], {3'h0, oc, hp, he, p, f});
    endtask
    // Thermistor and unit temperature warnings
    task automatic t_temp(input logic signed [11:0] th, ut, input logic [1:0] hot_open);
        @(posedge mclk);
        therm <= th;
        unit <= ut;
        snap;
        chk(cap[17:10] & 8'h60, {1'b0, hot_open, 5'h00});
    endtask
    // Supply byte encoding and saturation
    task automatic t_supply(input logic [9:0] v, input logic [7:0] exp);
        @(posedge mclk);
        supply <= v;
        snap;
        chk(cap[9:2], exp);
    endtask
    // Snapshot holds while inputs move; ready lasts one cycle
    task automatic t_hold;
        @(posedge mclk);
        plaus <= 1'b1;
        snap;
        @(negedge mclk);
        chk({7'h00, done}, 8'h00);
        @(posedge mclk);
        plaus <= 1'b0;
        cyc(3);
        chk({7'h00, gen[4]}, 8'h01);
        snap;
        chk({7'h00, cap[22]}, 8'h00);
    endtask
    // Persistent plausibility violation sets the static bit only
    task automatic t_static;
        @(posedge mclk);
        vt <= 1'b1;
        cyc(8);
        snap;
        chk({6'h00, cap[23], cap[18]}, 8'h00);
        cyc(40);
        snap;
        chk({6'h00, cap[23], cap[18]}, 8'h02);
        @(posedge mclk);
        vt <= 1'b0;
    endtask
    // Stale measurements: fault, error telegram and analogue reaction
    task automatic t_stale;
        @(posedge mclk);
        {meas_run, ana_on, sel} <= 3'b011;
        cyc(30);
        chk({7'h00, fault}, 8'h00);
        @(posedge mclk);
        meas_run <= 1'b1;
        avg_s <= 16'h000a;
        cyc(12);
        chk({7'h00, fault}, 8'h00);
        chk(ana_out, 8'h5a);
        @(posedge mclk);
        meas_run <= 1'b0;
        cyc(5);
        chk({7'h00, fault}, 8'h00);
        cyc(25);
        chk({7'h00, fault}, 8'h01);
        chk(ana_out, 8'hff);
        snap;
        chk({4'h0, cap[18], cap[10], cap[1:0]}, 8'h0d);
        @(posedge mclk);
        {sel, err_cfg} <= 2'b01;
        cyc(2);
        chk(ana_out, 8'h00);
        snap;
        chk({6'h00, cap[1:0]}, 8'h02);
        @(posedge mclk);
        meas_run <= 1'b1;
        cyc(10);
        chk({7'h00, fault}, 8'h00);
        chk(ana_out, 8'h5a);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_bits(1'b1, 1'b0, 1'b0, 1'b0, 8'h08, 8'h08, 3'h7);
        t_bits(1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 8'h08, 3'h0);
        t_bits(1'b0, 1'b0, 1'b1, 1'b1, 8'h03, 8'h10, 3'h1);
        t_bits(1'b0, 1'b0, 1'b0, 1'b0, 8'h02, 8'h10, 3'h0);
        t_bits(1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 8'h10, 3'h2);
        t_bits(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h08, 3'h0);
        for (int i = 2; i < 8; i++) begin
            t_bits(1'b0, 1'b0, 1'b0, 1'b0, 8'(i), 8'h08, 3'(i - 1));
        end
        t_temp(-12'sd51, 12'sd60, 2'b01);
        t_temp(-12'sd50, 12'sd61, 2'b10);
        t_temp(12'sd80, 12'sd20, 2'b00);
        t_temp(12'sd81, 12'sd20, 2'b01);
        t_supply(10'h064, 8'h64);
        t_supply(10'h0ff, 8'hff);
        t_supply(10'h100, 8'hff);
        t_supply(10'h000, 8'h00);
        t_hold;
        t_static;
        t_stale;
        end_sim;
    end
    // Overall run limit
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_sim;
    end
endmodule // wind_status_bench
`default_nettype wire
